// ==== verilog/fdwh_word_handler.sv ====
`timescale 1ns/1ps
`include "fdwh_defines.svh"
module fdwh_word_handler #(
  parameter int TRIP_DELAY_CYC  = `FDWH_TRIP_DELAY_CYC,
  parameter int MIRROR_CYC      = `FDWH_MIRROR_CYC,
  parameter bit FIELDBUS_FITTED = 1'b1
) (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire logic                         telegram_valid,
  input  wire fdwh_pkg::fdwh_telegram_type  telegram,
  input  wire logic [1:0]                   telegram_profile,
  input  wire logic                         mirror_select,
  input  wire logic [4:0]                   input_pins,
  input  wire fdwh_pkg::fdwh_drive_state_type drive_state,
  input  wire logic [15:0]                  out_freq_hz,
  input  wire logic [15:0]                  freq_low_limit,
  input  wire logic [15:0]                  freq_high_limit,
  input  wire logic                         relay_ramp_stop_sel,
  input  wire logic [15:0]                  adjust_amount,
  input  wire logic [15:0]                  ref_min,
  input  wire logic [15:0]                  ref_max,
  output logic                              serial_accepted,
  output logic [15:0]                       status_word,
  output logic [15:0]                       output_frequency_word,
  output logic [15:0]                       applied_control_word,
  output logic signed [16:0]                speed_setpoint,
  output logic                              reverse_dir,
  output logic                              ramp_stop,
  output logic                              jog1_sel,
  output logic                              jog2_sel,
  output logic                              relay_out,
  output logic                              trip_reset_pulse,
  output logic                              trip_out,
  output fdwh_pkg::fdwh_layout_type         active_layout
);
  import fdwh_pkg::*;

  // refuse counts that the timers cannot serve
  if (TRIP_DELAY_CYC < 1 || MIRROR_CYC < 1) begin : g_count_check
    $error("fdwh_word_handler: counts must be at least one");
  end

  logic [15:0]         cw_r;
  logic [15:0]         ref_r;
  logic                reset_bit_prev_r;
  logic                start_inh_r;
  logic [4:0]          mirror_r;
  logic [31:0]         mirror_cnt_r;
  logic [31:0]         trip_cnt_r;
  fdwh_trip_state_type trip_st_r;
  fdwh_trip_state_type trip_st_nxt;
  logic                fb_mode;
  logic                serial_ok;
  logic                on123;
  logic                rise7;
  logic                freq_nonzero;
  logic                freq_ok;
  logic signed [16:0]  ref_adj;
  logic [15:0]         st_nxt;
  logic [15:0]         span;
  logic [31:0]         scaled;
  logic                off23_evt;

  assign fb_mode   = (telegram_profile == `FDWH_PROFILE_FIELDBUS);
  assign serial_ok = !drive_state.local_ctrl;
  assign serial_accepted = serial_ok;

  always_comb begin
    if (mirror_select && FIELDBUS_FITTED) begin
      active_layout = FDWH_LAYOUT_MIRROR;
    end else if (fb_mode) begin
      active_layout = FDWH_LAYOUT_FIELDBUS;
    end else begin
      active_layout = FDWH_LAYOUT_NATIVE;
    end
  end

  // whole telegram taken at once, only when valid and serial control allowed
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cw_r  <= `FDWH_CW_RESET_VAL;
      ref_r <= `FDWH_REF_RESET_VAL;
    end else if (telegram_valid && serial_ok && telegram.control_word[`FDWH_CW_VALID]) begin
      cw_r  <= telegram.control_word;
      ref_r <= telegram.reference_word;
    end
  end
  assign applied_control_word = cw_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reset_bit_prev_r <= 1'b0;
    end else begin
      reset_bit_prev_r <= cw_r[`FDWH_CW_RESET];
    end
  end
  assign rise7 = cw_r[`FDWH_CW_RESET] && !reset_bit_prev_r;
  assign trip_reset_pulse = rise7;

  assign on123     = cw_r[`FDWH_CW_ON1] && cw_r[`FDWH_CW_ON2] && cw_r[`FDWH_CW_ON3];
  assign ramp_stop = fb_mode && !on123;
  assign jog1_sel  = fb_mode && cw_r[`FDWH_CW_JOG1];
  assign jog2_sel  = fb_mode && !cw_r[`FDWH_CW_JOG1] && cw_r[`FDWH_CW_JOG2];
  assign reverse_dir = ref_r[15];

  // signed reference adjust; slow-down has priority over catch-up
  always_comb begin
    ref_adj = $signed({ref_r[15], ref_r});
    if (fb_mode && cw_r[`FDWH_CW_SLOW]) begin
      ref_adj = ref_adj - $signed({1'b0, adjust_amount});
    end else if (fb_mode && cw_r[`FDWH_CW_CATCH]) begin
      ref_adj = ref_adj + $signed({1'b0, adjust_amount});
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      speed_setpoint <= 17'sh00000;
    end else begin
      speed_setpoint <= ref_adj;
    end
  end

  assign freq_nonzero = (out_freq_hz != 16'h0000);
  assign freq_ok = (out_freq_hz > freq_low_limit) && (out_freq_hz < freq_high_limit);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      relay_out <= 1'b0;
    end else begin
      relay_out <= relay_ramp_stop_sel && !freq_nonzero;
    end
  end

  // current-limit dwell timer leading to trip
  always_comb begin
    trip_st_nxt = trip_st_r;
    case (trip_st_r)
      FDWH_TRP_IDLE: begin
        if (drive_state.current_over) begin
          trip_st_nxt = FDWH_TRP_LIMIT;
        end
      end
      FDWH_TRP_LIMIT: begin
        if (!drive_state.current_over) begin
          trip_st_nxt = FDWH_TRP_IDLE;
        end else if (trip_cnt_r >= 32'(TRIP_DELAY_CYC - 1)) begin
          trip_st_nxt = FDWH_TRP_TRIP;
        end
      end
      FDWH_TRP_TRIP: begin
        if (rise7) begin
          trip_st_nxt = FDWH_TRP_IDLE;
        end
      end
      default: trip_st_nxt = FDWH_TRP_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trip_st_r <= FDWH_TRP_IDLE;
    end else begin
      trip_st_r <= trip_st_nxt;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trip_cnt_r <= 32'h0;
    end else if (trip_st_r == FDWH_TRP_LIMIT) begin
      trip_cnt_r <= trip_cnt_r + 32'h1;
    end else begin
      trip_cnt_r <= 32'h0;
    end
  end
  assign trip_out = (trip_st_r == FDWH_TRP_TRIP) || drive_state.trip;

  // start inhibit: set wins over the master's clear
  assign off23_evt = fb_mode && (!cw_r[`FDWH_CW_ON2] || !cw_r[`FDWH_CW_ON3]);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      start_inh_r <= 1'b1;
    end else if (rise7 || off23_evt) begin
      start_inh_r <= 1'b1;
    end else if (!cw_r[`FDWH_CW_ON1] && cw_r[`FDWH_CW_ON2] && cw_r[`FDWH_CW_ON3] && cw_r[`FDWH_CW_VALID]) begin
      start_inh_r <= 1'b0;
    end
  end

  // input mirror sampled once per refresh period
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mirror_cnt_r <= 32'h0;
      mirror_r     <= 5'h00;
    end else if (mirror_cnt_r >= 32'(MIRROR_CYC - 1)) begin
      mirror_cnt_r <= 32'h0;
      mirror_r     <= input_pins;
    end else begin
      mirror_cnt_r <= mirror_cnt_r + 32'h1;
    end
  end

  always_comb begin
    st_nxt = 16'h0000;
    st_nxt[`FDWH_ST_CTRL_READY]  = !drive_state.not_ready;
    st_nxt[`FDWH_ST_DRIVE_READY] = drive_state.drive_ready;
    st_nxt[`FDWH_ST_COAST]       = !drive_state.coasting_in;
    st_nxt[`FDWH_ST_TRIP]        = trip_out;
    st_nxt[`FDWH_ST_WARN]        = drive_state.warning;
    st_nxt[`FDWH_ST_SPEED_EQ]    = drive_state.speed_eq_ref;
    st_nxt[`FDWH_ST_SERIAL_OK]   = serial_ok;
    st_nxt[`FDWH_ST_FREQ_OK]     = freq_ok && !drive_state.freq_at_limit;
    st_nxt[`FDWH_ST_RUNNING]     = drive_state.start_signal || freq_nonzero;
    st_nxt[`FDWH_ST_VOLT]        = drive_state.dc_volt_warn;
    st_nxt[`FDWH_ST_CURR]        = drive_state.current_over;
    st_nxt[`FDWH_ST_THERM]       = drive_state.thermal_warn;
    case (active_layout)
      FDWH_LAYOUT_MIRROR: begin
        st_nxt[`FDWH_ST_IN_A]  = mirror_r[0];
        st_nxt[`FDWH_ST_IN_B]  = mirror_r[1];
        st_nxt[`FDWH_ST_VOLT]  = mirror_r[2];
        st_nxt[`FDWH_ST_CURR]  = mirror_r[3];
        st_nxt[`FDWH_ST_THERM] = mirror_r[4];
      end
      FDWH_LAYOUT_FIELDBUS: begin
        st_nxt[`FDWH_ST_CTRL_READY] = on123 && !drive_state.not_ready;
        st_nxt[`FDWH_ST_COAST] = on123 && cw_r[`FDWH_CW_COAST_N] && !trip_out;
        st_nxt[`FDWH_ST_OFF2] = !cw_r[`FDWH_CW_ON2];
        st_nxt[`FDWH_ST_OFF3] = !cw_r[`FDWH_CW_ON3];
        st_nxt[`FDWH_ST_START_INH] = start_inh_r;
        st_nxt[`FDWH_ST_WARN] = drive_state.warning;
      end
      default: begin
      end
    endcase
  end

  // output frequency scaled to the low..high limit span
  always_comb begin
    span   = freq_high_limit - freq_low_limit;
    scaled = 32'h0;
    if (span != 16'h0000) begin
      scaled = (32'(out_freq_hz - freq_low_limit) * 32'(`FDWH_FULL_SCALE)) / 32'(span);
      if (out_freq_hz < freq_low_limit) begin
        scaled = 32'h0;
      end else if (scaled > 32'h7fff) begin
        scaled = 32'h7fff;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_word           <= 16'h0000;
      output_frequency_word <= 16'h0000;
    end else begin
      status_word           <= st_nxt;
      output_frequency_word <= scaled[15:0];
    end
  end

  trip_reset_edge_a : assert property (@(posedge clk_sys) disable iff (reset)
    trip_reset_pulse |=> !trip_reset_pulse) else $error("trip reset pulse longer than one cycle");
  ignore_invalid_a : assert property (@(posedge clk_sys) disable iff (reset)
    (telegram_valid && !telegram.control_word[`FDWH_CW_VALID]) |=> $stable(cw_r)) else $error("invalid word applied");
  slow_priority_a : assert property (@(posedge clk_sys) disable iff (reset)
    (fb_mode && cw_r[`FDWH_CW_SLOW] && cw_r[`FDWH_CW_CATCH] && adjust_amount != 16'h0)
    |=> speed_setpoint < $signed({$past(ref_r[15]), $past(ref_r)})) else $error("slow-down lost priority");
  off_mirror_a : assert property (@(posedge clk_sys) disable iff (reset)
    (active_layout == FDWH_LAYOUT_FIELDBUS) |=> status_word[`FDWH_ST_OFF2] == !$past(cw_r[`FDWH_CW_ON2]))
    else $error("status off2 mismatch");
  serial_bit_a : assert property (@(posedge clk_sys) disable iff (reset)
    drive_state.local_ctrl |=> !status_word[`FDWH_ST_SERIAL_OK]) else $error("serial bit set in local mode");
  running_bit_a : assert property (@(posedge clk_sys) disable iff (reset)
    (out_freq_hz != 16'h0) |=> status_word[`FDWH_ST_RUNNING]) else $error("running bit missing");
  start_inhibit_a : assert property (@(posedge clk_sys) disable iff (reset)
    rise7 |=> start_inh_r) else $error("start inhibit not set after reset");
  ramp_stop_a : assert property (@(posedge clk_sys) disable iff (reset)
    (fb_mode && !cw_r[`FDWH_CW_ON1]) |-> ramp_stop) else $error("ramp stop missing");
  relay_zero_a : assert property (@(posedge clk_sys) disable iff (reset)
    (relay_ramp_stop_sel && out_freq_hz == 16'h0) |=> relay_out) else $error("relay not energised");

  // an accepted telegram lands as one pair
  sequence accept_s;
    telegram_valid && serial_ok && telegram.control_word[`FDWH_CW_VALID];
  endsequence
  latch_pair_a : assert property (@(posedge clk_sys) disable iff (reset)
    accept_s |=> (cw_r == $past(telegram.control_word)) && (ref_r == $past(telegram.reference_word)))
    else $error("telegram words not latched together");

  // low then high on the latched reset bit
  sequence reset_edge_s;
    !cw_r[`FDWH_CW_RESET] ##1 cw_r[`FDWH_CW_RESET];
  endsequence
  reset_edge_pulse_a : assert property (@(posedge clk_sys) disable iff (reset)
    reset_edge_s |-> trip_reset_pulse) else $error("trip reset pulse missing on rising edge");

  // dwell timer run out while still over the ceiling
  sequence dwell_done_s;
    (trip_st_r == FDWH_TRP_LIMIT) && drive_state.current_over && (trip_cnt_r >= 32'(TRIP_DELAY_CYC - 1));
  endsequence
  trip_entry_a : assert property (@(posedge clk_sys) disable iff (reset)
    dwell_done_s |=> trip_out) else $error("trip not entered after dwell");

  // master's release pattern with no new set event
  sequence inhibit_release_s;
    !cw_r[`FDWH_CW_ON1] && cw_r[`FDWH_CW_ON2] && cw_r[`FDWH_CW_ON3] && cw_r[`FDWH_CW_VALID] && !rise7;
  endsequence
  inhibit_clear_a : assert property (@(posedge clk_sys) disable iff (reset)
    inhibit_release_s |=> !start_inh_r) else $error("start inhibit not released");

  mirror_pin_a : assert property (@(posedge clk_sys) disable iff (reset)
    (active_layout == FDWH_LAYOUT_MIRROR) |=> status_word[`FDWH_ST_IN_B] == $past(mirror_r[1]))
    else $error("mirrored pin missing");
  spare_zero_a : assert property (@(posedge clk_sys) disable iff (reset)
    (active_layout == FDWH_LAYOUT_FIELDBUS) |=> !status_word[`FDWH_ST_IN_B]) else $error("spare bit set");
  coast_trip_a : assert property (@(posedge clk_sys) disable iff (reset)
    (active_layout == FDWH_LAYOUT_FIELDBUS && trip_out) |=> !status_word[`FDWH_ST_COAST])
    else $error("coast bit set while tripped");
  freq_floor_a : assert property (@(posedge clk_sys) disable iff (reset)
    (out_freq_hz <= freq_low_limit) |=> (output_frequency_word == 16'h0000)) else $error("frequency word not zero");
  freq_limit_a : assert property (@(posedge clk_sys) disable iff (reset)
    (out_freq_hz >= freq_high_limit) |=> !status_word[`FDWH_ST_FREQ_OK]) else $error("limit bit set at limit");
endmodule

// ==== verilog/fdwh_defines.svh ====
`ifndef FDWH_DEFINES_SVH
`define FDWH_DEFINES_SVH
// status bit positions
`define FDWH_ST_CTRL_READY   0
`define FDWH_ST_DRIVE_READY  1
`define FDWH_ST_COAST        2
`define FDWH_ST_TRIP         3
`define FDWH_ST_OFF2         4
`define FDWH_ST_OFF3         5
`define FDWH_ST_IN_A         5
`define FDWH_ST_START_INH    6
`define FDWH_ST_WARN         7
`define FDWH_ST_SPEED_EQ     8
`define FDWH_ST_SERIAL_OK    9
`define FDWH_ST_FREQ_OK      10
`define FDWH_ST_RUNNING      11
`define FDWH_ST_IN_B         12
`define FDWH_ST_VOLT         13
`define FDWH_ST_CURR         14
`define FDWH_ST_THERM        15
// control bit positions
`define FDWH_CW_ON1          0
`define FDWH_CW_ON2          1
`define FDWH_CW_ON3          2
`define FDWH_CW_COAST_N      3
`define FDWH_CW_RESET        7
`define FDWH_CW_JOG1         8
`define FDWH_CW_JOG2         9
`define FDWH_CW_VALID        10
`define FDWH_CW_SLOW         11
`define FDWH_CW_CATCH        12
// telegram profile code for fieldbus layout
`define FDWH_PROFILE_FIELDBUS 2'h0
// scaling: 100 percent of span
`define FDWH_FULL_SCALE      16'h4000
// input refresh time in microseconds and derived sample period
`define FDWH_MIRROR_US       10000
`define FDWH_CLK_MHZ         10
`define FDWH_MIRROR_CYC      (`FDWH_MIRROR_US * `FDWH_CLK_MHZ)
// current-limit dwell before a trip, in clock cycles; arbitrary default
`define FDWH_TRIP_DELAY_CYC  50000
// reset values
`define FDWH_CW_RESET_VAL    16'h0000
`define FDWH_REF_RESET_VAL   16'h0000
`endif

// ==== verilog/fdwh_pkg.sv ====
package fdwh_pkg;
  typedef enum logic [1:0] {
    FDWH_LAYOUT_NATIVE   = 2'h0,
    FDWH_LAYOUT_MIRROR   = 2'h1,
    FDWH_LAYOUT_FIELDBUS = 2'h2
  } fdwh_layout_type;

  typedef struct packed {
    logic [15:0] control_word;
    logic [15:0] reference_word;
  } fdwh_telegram_type;

  typedef struct packed {
    logic        speed_eq_ref;
    logic        local_ctrl;
    logic        freq_at_limit;
    logic        start_signal;
    logic        dc_volt_warn;
    logic        current_over;
    logic        thermal_warn;
    logic        drive_ready;
    logic        coasting_in;
    logic        warning;
    logic        trip;
    logic        not_ready;
  } fdwh_drive_state_type;

  typedef enum logic [2:0] {
    FDWH_TRP_IDLE  = 3'b001,
    FDWH_TRP_LIMIT = 3'b010,
    FDWH_TRP_TRIP  = 3'b100
  } fdwh_trip_state_type;
endpackage

// ==== tb/fdwh_master_model.sv ====
`timescale 1ns/1ps
module fdwh_master_model (
  input  wire logic                   clk_sys,
  output fdwh_pkg::fdwh_telegram_type telegram,
  output logic                        telegram_valid
);
  import fdwh_pkg::*;
  initial begin
    telegram_valid = 1'b0;
    telegram       = '0;
  end
  // one telegram per call; words show the inverse once the pulse ends
  task automatic send(input logic [15:0] cw, input logic [15:0] ref_w);
    @(negedge clk_sys);
    telegram_valid = 1'b1;
    telegram       = {cw, ref_w};
    @(negedge clk_sys);
    telegram_valid = 1'b0;
    telegram       = ~telegram;
  endtask
endmodule

// ==== tb/fdwh_word_handler_bench.sv ====
`timescale 1ns/1ps
module fdwh_word_handler_bench;
  import fdwh_pkg::*;
  logic                 clk_sys    = 1'b0;
  logic                 reset      = 1'b1;
  logic [1:0]           profile    = 2'h0;
  logic                 mirror_sel = 1'b0;
  logic [4:0]           pins       = 5'h00;
  fdwh_drive_state_type ds         = '0;
  logic [15:0]          freq       = 16'h0019;
  logic [15:0]          adj        = 16'h0100;
  logic                 relay_sel  = 1'b1;
  logic                 telegram_valid, serial_accepted, reverse_dir, ramp_stop;
  logic                 jog1_sel, jog2_sel, relay_out, trip_reset_pulse, trip_out;
  fdwh_telegram_type    telegram;
  logic [15:0]          status_word, output_frequency_word, applied_control_word;
  logic signed [16:0]   speed_setpoint;
  fdwh_layout_type      active_layout;
  int                   n_fail = 0;
  int                   comparisons = 0;
  int                   pulses = 0;
  int                   sb[5] = '{8, 11, 13, 14, 15};
  int                   fb[5] = '{11, 8, 7, 6, 5};
  int                   k;

  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (trip_reset_pulse === 1'b1) pulses++;

  fdwh_master_model mst (.clk_sys(clk_sys), .telegram(telegram), .telegram_valid(telegram_valid));

  fdwh_word_handler #(.TRIP_DELAY_CYC(8), .MIRROR_CYC(4)) dut (
    .clk_sys(clk_sys), .reset(reset), .telegram_valid(telegram_valid), .telegram(telegram),
    .telegram_profile(profile), .mirror_select(mirror_sel), .input_pins(pins), .drive_state(ds),
    .out_freq_hz(freq), .freq_low_limit(16'h0000), .freq_high_limit(16'h0032),
    .relay_ramp_stop_sel(relay_sel), .adjust_amount(adj), .ref_min(16'h0000), .ref_max(16'h0032),
    .serial_accepted(serial_accepted), .status_word(status_word),
    .output_frequency_word(output_frequency_word), .applied_control_word(applied_control_word),
    .speed_setpoint(speed_setpoint), .reverse_dir(reverse_dir), .ramp_stop(ramp_stop),
    .jog1_sel(jog1_sel), .jog2_sel(jog2_sel), .relay_out(relay_out),
    .trip_reset_pulse(trip_reset_pulse), .trip_out(trip_out), .active_layout(active_layout));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic tx(input logic [15:0] cw, input logic [15:0] r);
    mst.send(cw, r);
    tick(4);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic sc_start;
    chk(status_word[6], 1'b1, "inhibit at power-up");
    chk(active_layout, FDWH_LAYOUT_FIELDBUS, "layout");
    tx(16'h047f, 16'h2000);
    chk(applied_control_word, 16'h047f, "cw latched");
    chk(speed_setpoint, 17'h02000, "setpoint");
    chk(ramp_stop, 1'b0, "run permitted");
    chk({status_word[5:4], status_word[2], status_word[0]}, 4'h3, "ready bits");
    chk({status_word[12], status_word[9]}, 2'h1, "serial ok, spare");
  endtask

  task automatic sc_refuse;
    tx(16'h007e, 16'h1000);
    chk({applied_control_word, speed_setpoint[15:0]}, {16'h047f, 16'h2000}, "invalid ignored");
    ds.local_ctrl = 1'b1;
    tick(3);
    chk({serial_accepted, status_word[9]}, 2'h0, "local");
    tx(16'h047e, 16'h1000);
    chk(applied_control_word, 16'h047f, "local ignored");
    ds.local_ctrl = 1'b0;
  endtask

  task automatic sc_off;
    tx(16'h047d, 16'h2000);
    chk({ramp_stop, status_word[0], status_word[2], status_word[4]}, 4'h9, "off2");
    chk(status_word[6], 1'b1, "inhibit after off2");
    tx(16'h047b, 16'h2000);
    chk({ramp_stop, status_word[5]}, 2'h3, "off3");
    tx(16'h0406, 16'h2000);
    chk({status_word[6], status_word[0]}, 2'h0, "inhibit cleared");
  endtask

  task automatic sc_ref;
    tx(16'h047f, 16'he000);
    chk({reverse_dir, speed_setpoint}, 18'h3e000, "reverse");
    tx(16'h0c7f, 16'h2000);
    chk(speed_setpoint, 17'h01f00, "slow down");
    adj = 16'h0040;
    tick(3);
    chk(speed_setpoint, 17'h01fc0, "slow down small step");
    adj = 16'h0100;
    tx(16'h147f, 16'h2000);
    chk(speed_setpoint, 17'h02100, "catch up");
    tx(16'h1c7f, 16'h2000);
    chk(speed_setpoint, 17'h01f00, "both");
    tx(16'h057f, 16'h2000);
    chk({jog1_sel, jog2_sel}, 2'h2, "jog1");
    tx(16'h067f, 16'h2000);
    chk({jog1_sel, jog2_sel}, 2'h1, "jog2");
    tx(16'h047f, 16'h2000);
  endtask

  task automatic sc_state;
    freq = 16'h0000;
    ds = '0;
    tick(3);
    chk({status_word[15:13], status_word[11], status_word[8]}, 5'h00, "idle bits");
    chk(relay_out, 1'b1, "relay at 0 Hz");
    relay_sel = 1'b0;
    tick(3);
    chk(relay_out, 1'b0, "relay function not selected");
    relay_sel = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ds = '0;
      ds[fb[i]] = 1'b1;
      tick(3);
      chk(status_word[sb[i]], 1'b1, "state bit");
    end
    ds = '0;
    freq = 16'h0019;
    tick(3);
    chk({relay_out, status_word[10], output_frequency_word}, 18'h12000, "mid span");
    freq = 16'h0032;
    tick(3);
    chk({status_word[10], output_frequency_word}, 17'h04000, "at high");
    freq = 16'h0019;
    ds.freq_at_limit = 1'b1;
    tick(3);
    chk(status_word[10], 1'b0, "limit flag");
    ds = '0;
    ds.current_over = 1'b1;
    k = 0;
    while (trip_out !== 1'b1 && k < 30) begin
      tick(1);
      k++;
    end
    chk(k >= 6 && k <= 12, 1'b1, "trip delay");
    if (k >= 30) end_sim();
    ds = '0;
    tick(2);
    chk(status_word[2], 1'b0, "coast on trip");
  endtask

  task automatic sc_trip;
    pulses = 0;
    tx(16'h04ff, 16'h2000);
    chk(pulses, 1, "reset edge");
    chk({trip_out, status_word[6]}, 2'h1, "trip cleared");
    tx(16'h04ff, 16'h2000);
    chk(pulses, 1, "level no reset");
  endtask

  task automatic sc_mirror;
    profile = 2'h1;
    mirror_sel = 1'b1;
    pins = 5'h15;
    tick(10);
    chk(active_layout, FDWH_LAYOUT_MIRROR, "mirror layout");
    chk({status_word[15:12], status_word[5]}, 5'h15, "pins a");
    pins = 5'h0a;
    tick(10);
    chk({status_word[15:12], status_word[5]}, 5'h0a, "pins b");
    mirror_sel = 1'b0;
    tick(3);
    chk(active_layout, FDWH_LAYOUT_NATIVE, "profile not zero");
    chk({status_word[6], status_word[4]}, 2'h0, "no fieldbus bits");
  endtask

  initial begin
    tick(3);
    reset = 1'b0;
    tick(3);
    sc_start();
    sc_refuse();
    sc_off();
    sc_ref();
    sc_state();
    sc_trip();
    sc_mirror();
    end_sim();
  end
endmodule
